// ---- rtl/irq_prio_pkg.sv ----
package irq_prio_pkg;

  // ****************************************************************
  // source numbering
  // ****************************************************************
  localparam int NUM_SRC    = 9;   // three external lines and six peripherals
  localparam int NUM_CAND   = 10;  // sources plus the encoded-level candidate
  localparam int ENC_IDX    = 9;   // candidate slot of the encoded-level bus
  localparam int SRC_LINE7  = 0;
  localparam int SRC_LINE4  = 1;
  localparam int SRC_LINE1  = 2;
  localparam int SRC_TIMER1 = 3;
  localparam int SRC_DOG    = 5;
  localparam int SRC_UART1  = 6;
  localparam int SRC_TWO    = 8;

  // ****************************************************************
  // levels and priorities
  // ****************************************************************
  localparam logic [2:0] LEVEL_NONE   = 3'h0;  // level zero means source disabled
  localparam logic [2:0] LEVEL_NMI    = 3'h7;  // passes any mask
  localparam logic [1:0] ENC_REL_PRIO = 2'h3;

  // reset configuration, source 8 in the top bits down to source 0
  localparam logic [26:0] DEF_LEVELS = {3'h3, 3'h3, 3'h3, 3'h7, 3'h5, 3'h5, 3'h1, 3'h4, 3'h7};
  localparam logic [17:0] DEF_PRIOS  = {2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3, 2'h1, 2'h0, 2'h3};
  localparam logic [8:0]  DEF_AUTOVEC = 9'h1df;  // all but the watchdog

  // ****************************************************************
  // vectors and timing
  // ****************************************************************
  localparam logic [7:0] AUTOVECTOR_BASE = 8'h18;  // entry for level n is base plus n
  localparam logic [7:0] SPURIOUS_VECTOR = 8'h18;  // used when no source answers
  localparam int CLK_PERIOD_NS      = 10;
  localparam int VECTOR_WAIT_NS     = 160;
  localparam int VECTOR_WAIT_CYCLES = (VECTOR_WAIT_NS / CLK_PERIOD_NS < 1) ? 1 :
                                      VECTOR_WAIT_NS / CLK_PERIOD_NS;

  typedef enum logic [0:0] {ACK_IDLE, ACK_WAIT} ack_state_e;

endpackage : irq_prio_pkg

// ---- rtl/irq_source_cell.sv ----
`timescale 1ns/1ps
module irq_source_cell #(
  parameter logic [2:0] DEF_LEVEL   = 3'h0,
  parameter logic [1:0] DEF_PRIO    = 2'h0,
  parameter logic       DEF_AUTOVEC = 1'b1
) (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       cfg_we_i,
  input  wire logic [2:0] cfg_level_i,
  input  wire logic [1:0] cfg_prio_i,
  input  wire logic       cfg_autovec_i,
  input  wire logic       request_i,
  input  wire logic [2:0] mask_i,
  output logic      [4:0] key_o,
  output logic            eligible_o,
  output logic            autovec_o
);

  logic [2:0] level;
  logic [1:0] prio;

  // per-source level, relative priority and vector mode
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      level     <= DEF_LEVEL;
      prio      <= DEF_PRIO;
      autovec_o <= DEF_AUTOVEC;
    end else if (cfg_we_i) begin
      level     <= cfg_level_i;  // R7
      prio      <= cfg_prio_i;   // R7
      autovec_o <= cfg_autovec_i;
    end
  end

  // request counts only above the mask, level seven always
  always_comb begin
    key_o      = {level, prio};
    eligible_o = request_i && (level != irq_prio_pkg::LEVEL_NONE) &&
                 ((level > mask_i) || (level == irq_prio_pkg::LEVEL_NMI));  // R1 R2 R11
  end

endmodule : irq_source_cell

// ---- rtl/board_interrupt_priority_logic.sv ----
// Overview of operation
// R1 - seven request levels; level zero means no request.
// R2 - accept only above status mask; acknowledge at instruction end.
// R3 - a vectoring source answers the acknowledge with its vector number.
// R4 - autovectored source gives no vector; entry follows the level.
// R5 - three external lines: encoded level bus or individual lines seven, four, one.
// R6 - six peripheral sources: two timers, watchdog, two UARTs, two-wire bus.
// R7 - every source programmable to any level, relative priority 0 to 3.
// R8 - watchdog defaults to level 7, priority 2, vectored.
// R9 - UARTs level 3 priority 2 and 1, two-wire bus priority 0, autovector.
// R10 - timers level 5, priorities 3 and 2, autovector.
// R11 - abort on level-seven line is non-maskable, priority 3, autovector.
// R12 - abort circuit debounces and holds request at least 30 us.
// R13 - level-one line defaults to level 1, priority 1, autovector.
// R14 - board stays in individual-line mode; encoded mode loses the network line.
// R15 - highest level, then highest relative priority wins; only it is acknowledged.
`timescale 1ns/1ps
module board_interrupt_priority_logic (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       level_seven_request_line_n_i,
  input  wire logic       level_four_request_line_n_i,
  input  wire logic       level_one_request_line_n_i,
  input  wire logic       encoded_mode_i,
  input  wire logic [5:0] peripheral_request_i,
  input  wire logic [2:0] current_mask_i,
  input  wire logic       instruction_done_i,
  input  wire logic       cfg_write_i,
  input  wire logic [3:0] cfg_select_i,
  input  wire logic [2:0] cfg_level_i,
  input  wire logic [1:0] cfg_prio_i,
  input  wire logic       cfg_autovector_i,
  input  wire logic       source_vector_valid_i,
  input  wire logic [7:0] source_vector_i,
  output logic            request_pending_o,
  output logic      [2:0] pending_level_o,
  output logic            iack_o,
  output logic      [2:0] iack_level_o,
  output logic      [9:0] iack_source_o,
  output logic            autovectored_o,
  output logic      [7:0] vector_o,
  output logic            vector_valid_o
);

  // ****************************************************************
  // source requests
  // ****************************************************************
  logic [8:0]  src_request;
  logic [2:0]  line_active;
  logic [2:0]  enc_level;
  logic [9:0]  cand_ok;
  logic [9:0]  cand_auto;
  logic [4:0]  cand_key [10];

  // external lines are active low; encoded mode reads them as one level
  always_comb begin
    line_active = ~{level_one_request_line_n_i, level_four_request_line_n_i,
                    level_seven_request_line_n_i};
    enc_level   = ~{level_seven_request_line_n_i, level_four_request_line_n_i,
                    level_one_request_line_n_i};  // R5
    src_request = {peripheral_request_i,
                   line_active & {3{~encoded_mode_i}}};  // R5 R6 R14
  end

  // one configurable cell per source
  genvar g;
  generate
    for (g = 0; g < irq_prio_pkg::NUM_SRC; g++) begin : g_src
      irq_source_cell #(
        .DEF_LEVEL   (irq_prio_pkg::DEF_LEVELS[3*g +: 3]),  // R8 R9 R10 R11 R13
        .DEF_PRIO    (irq_prio_pkg::DEF_PRIOS[2*g +: 2]),
        .DEF_AUTOVEC (irq_prio_pkg::DEF_AUTOVEC[g])
      ) u_cell (
        .clk_i         (clk_i),
        .sys_rst_i     (sys_rst_i),
        .cfg_we_i      (cfg_write_i && (cfg_select_i == 4'(g))),  // R7
        .cfg_level_i   (cfg_level_i),
        .cfg_prio_i    (cfg_prio_i),
        .cfg_autovec_i (cfg_autovector_i),
        .request_i     (src_request[g]),
        .mask_i        (current_mask_i),
        .key_o         (cand_key[g]),
        .eligible_o    (cand_ok[g]),
        .autovec_o     (cand_auto[g])
      );
    end
  endgenerate

  // encoded level bus as its own candidate, always autovectored
  // continuous drive keeps one driver kind on the candidate arrays
  assign cand_key[irq_prio_pkg::ENC_IDX]  = {enc_level, irq_prio_pkg::ENC_REL_PRIO};
  assign cand_auto[irq_prio_pkg::ENC_IDX] = 1'b1;
  assign cand_ok[irq_prio_pkg::ENC_IDX]   = encoded_mode_i &&
      (enc_level != irq_prio_pkg::LEVEL_NONE) &&
      ((enc_level > current_mask_i) || (enc_level == irq_prio_pkg::LEVEL_NMI));  // R5 R2

  // ****************************************************************
  // arbitration
  // ****************************************************************
  logic       win_found;
  logic [4:0] win_key;
  logic [3:0] win_idx;

  // largest level/priority key wins, lowest slot breaks exact ties
  always_comb begin
    win_found = 1'b0;
    win_key   = 5'h00;
    win_idx   = 4'h0;
    for (int i = 0; i < irq_prio_pkg::NUM_CAND; i++) begin
      if (cand_ok[i] && (!win_found || (cand_key[i] > win_key))) begin  // R15
        win_found = 1'b1;
        win_key   = cand_key[i];
        win_idx   = 4'(i);
      end
    end
  end

  // registered view of the current winner
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      request_pending_o <= 1'b0;
      pending_level_o   <= 3'h0;
    end else begin
      request_pending_o <= win_found;
      pending_level_o   <= win_found ? win_key[4:2] : irq_prio_pkg::LEVEL_NONE;
    end
  end

  // ****************************************************************
  // acknowledge cycle
  // ****************************************************************
  irq_prio_pkg::ack_state_e state;
  logic [4:0] wait_cnt;

  // start at an instruction boundary, then fetch or form the vector
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state          <= irq_prio_pkg::ACK_IDLE;
      iack_o         <= 1'b0;
      iack_level_o   <= 3'h0;
      iack_source_o  <= 10'h000;
      autovectored_o <= 1'b0;
      vector_o       <= 8'h00;
      vector_valid_o <= 1'b0;
      wait_cnt       <= 5'h00;
    end else begin
      vector_valid_o <= 1'b0;
      case (state)
        irq_prio_pkg::ACK_IDLE: begin
          if (instruction_done_i && win_found) begin  // R2
            state          <= irq_prio_pkg::ACK_WAIT;
            iack_o         <= 1'b1;
            iack_level_o   <= win_key[4:2];
            iack_source_o  <= 10'h001 << win_idx;  // R15
            autovectored_o <= cand_auto[win_idx];
            wait_cnt       <= 5'h00;
          end
        end
        irq_prio_pkg::ACK_WAIT: begin
          wait_cnt <= wait_cnt + 5'h01;
          if (autovectored_o) begin
            vector_o       <= irq_prio_pkg::AUTOVECTOR_BASE + 8'(iack_level_o);  // R4
            vector_valid_o <= 1'b1;
            iack_o         <= 1'b0;
            state          <= irq_prio_pkg::ACK_IDLE;
          end else if (source_vector_valid_i) begin
            vector_o       <= source_vector_i;  // R3
            vector_valid_o <= 1'b1;
            iack_o         <= 1'b0;
            state          <= irq_prio_pkg::ACK_IDLE;
          end else if (wait_cnt == 5'(irq_prio_pkg::VECTOR_WAIT_CYCLES - 1)) begin
            vector_o       <= irq_prio_pkg::SPURIOUS_VECTOR;  // silent source
            vector_valid_o <= 1'b1;
            iack_o         <= 1'b0;
            state          <= irq_prio_pkg::ACK_IDLE;
          end
        end
        default: begin
          state  <= irq_prio_pkg::ACK_IDLE;
          iack_o <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_ack_at_boundary: assert property ($rose(iack_o) |-> $past(instruction_done_i)) // R2
    else $error("acknowledge started off an instruction boundary");
  a_ack_above_mask: assert property ($rose(iack_o) |->
      (iack_level_o > $past(current_mask_i)) || (iack_level_o == 3'h7)) // R2 R11
    else $error("acknowledged level not above mask");
  a_ack_level_real: assert property (iack_o |-> iack_level_o != 3'h0) // R1
    else $error("acknowledge at level zero");
  a_autovec_entry: assert property (iack_o && autovectored_o |=>
      vector_valid_o && !iack_o &&
      (vector_o == irq_prio_pkg::AUTOVECTOR_BASE + 8'($past(iack_level_o)))) // R4
    else $error("autovector entry wrong");
  a_vector_passed: assert property (iack_o && !autovectored_o && source_vector_valid_i |=>
      vector_valid_o && (vector_o == $past(source_vector_i))) // R3
    else $error("source vector not passed on");
  a_ack_bounded: assert property ($rose(iack_o) |-> ##[1:16] !iack_o) // R2
    else $error("acknowledge did not finish");
  a_single_winner: assert property ($rose(iack_o) |->
      $onehot(iack_source_o) && (iack_level_o == $past(win_key[4:2]))) // R15
    else $error("winner not acknowledged alone");
  a_encoded_gate: assert property (!encoded_mode_i |-> !cand_ok[9]) // R14
    else $error("encoded candidate outside encoded mode");
  a_lines_gated: assert property (encoded_mode_i |-> cand_ok[2:0] == 3'h0) // R5
    else $error("individual lines active in encoded mode");
  a_defaults_high: assert property ($fell(sys_rst_i) |->
      (cand_key[5] == 5'h1e) && !cand_auto[5] && (cand_key[0] == 5'h1f) &&
      (cand_key[3] == 5'h17) && (cand_key[4] == 5'h16)) // R8 R10 R11
    else $error("high-level defaults wrong");
  a_defaults_low: assert property ($fell(sys_rst_i) |->
      (cand_key[6] == 5'h0e) && (cand_key[7] == 5'h0d) && (cand_key[8] == 5'h0c) &&
      (cand_key[2] == 5'h05) && cand_auto[2]) // R9 R13
    else $error("low-level defaults wrong");

  c_autovec_ack: cover property (iack_o && autovectored_o ##1 vector_valid_o);
  c_vectored_ack: cover property (iack_o && !autovectored_o && source_vector_valid_i);
  c_spurious_ack: cover property (vector_valid_o &&
                                  vector_o == irq_prio_pkg::SPURIOUS_VECTOR && $past(iack_o));
  c_encoded_ack: cover property ($rose(iack_o) && iack_source_o[9]);

endmodule : board_interrupt_priority_logic

// ---- sim/irq_source_model.sv ----
`timescale 1ns/1ps
module irq_source_model #(
  parameter int ABORT_HOLD = 3000  // 30 us of the 100 MHz clock
) (
  input  wire logic       clk_i,
  input  wire logic       iack_i,
  input  wire logic       autovectored_i,
  input  wire logic [2:0] lines_i,
  input  wire logic [5:0] periph_i,
  input  wire logic       abort_press_i,
  input  wire logic [7:0] vec_i,
  input  wire logic [4:0] vec_delay_i,
  output logic      [2:0] lines_n_o,
  output logic      [5:0] periph_o,
  output logic            vec_valid_o,
  output logic      [7:0] vec_o
);
  // ****************************************************************
  // request sources and vector answer
  // ****************************************************************
  logic [11:0] abort_cnt = 12'h000;  // no press yet: line seven idle from the start
  logic [4:0]  wait_cnt = 5'h00;

  // debounced abort holds its line for the full press time
  always_ff @(posedge clk_i) begin
    if (abort_press_i) abort_cnt <= 12'(ABORT_HOLD);
    else if (abort_cnt != 12'h000) abort_cnt <= abort_cnt - 12'h001;
  end

  // cycles spent in a vectored acknowledge
  always_ff @(posedge clk_i) begin
    if (!iack_i || autovectored_i) wait_cnt <= 5'h00;
    else wait_cnt <= wait_cnt + 5'h01;
  end

  // line levels are active low; a silent source drives the inverted vector
  assign lines_n_o = ~{lines_i[2] | (abort_cnt != 12'h000), lines_i[1:0]};
  assign periph_o = periph_i;
  assign vec_valid_o = iack_i && !autovectored_i && vec_delay_i != 5'h00
                       && wait_cnt == vec_delay_i;
  assign vec_o = vec_valid_o ? vec_i : ~vec_i;
endmodule : irq_source_model

// ---- sim/board_interrupt_priority_logic_tb_top.sv ----
`timescale 1ns/1ps
module board_interrupt_priority_logic_tb_top;
  logic clk_i, sys_rst_i, done, enc, cfg_we, cfg_av, press, svv, pend, iack, autov, vval;
  logic [3:0] cfg_sel;
  logic [2:0] mask, cfg_lvl, lines, lines_n, plev, ilev;
  logic [1:0] cfg_pr;
  logic [5:0] periph, per_req;
  logic [7:0] vec, sv, vout;
  logic [4:0] vdly;
  logic [9:0] isrc;
  int mismatches, cmp_count, cycles;

  irq_source_model irq_source_model_i (.clk_i(clk_i), .iack_i(iack), .autovectored_i(autov),
    .lines_i(lines), .periph_i(periph), .abort_press_i(press), .vec_i(vec),
    .vec_delay_i(vdly), .lines_n_o(lines_n), .periph_o(per_req), .vec_valid_o(svv),
    .vec_o(sv));
  board_interrupt_priority_logic board_interrupt_priority_logic_i (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .level_seven_request_line_n_i(lines_n[2]),
    .level_four_request_line_n_i(lines_n[1]), .level_one_request_line_n_i(lines_n[0]),
    .encoded_mode_i(enc), .peripheral_request_i(per_req), .current_mask_i(mask),
    .instruction_done_i(done), .cfg_write_i(cfg_we), .cfg_select_i(cfg_sel),
    .cfg_level_i(cfg_lvl), .cfg_prio_i(cfg_pr), .cfg_autovector_i(cfg_av),
    .source_vector_valid_i(svv), .source_vector_i(sv), .request_pending_o(pend),
    .pending_level_o(plev), .iack_o(iack), .iack_level_o(ilev), .iack_source_o(isrc),
    .autovectored_o(autov), .vector_o(vout), .vector_valid_o(vval));

  // ****************************************************************
  // clock, timeout and reporting
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // cut a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles >= 20000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // ****************************************************************
  // shared drivers
  // ****************************************************************
  task automatic ack(input logic [2:0] lvl, input logic [9:0] src, input logic av,
                     input logic [7:0] v);
    int n;
    n = 0;
    done = 1'b1;
    @(negedge clk_i);
    done = 1'b0;
    check(iack, 1'b1);
    check(ilev, lvl);
    check(isrc, src);
    check(autov, av);
    while (vval !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    check(vval, 1'b1);
    check(vout, v);
    @(negedge clk_i);
    check(vval, 1'b0);
  endtask : ack

  task automatic cfg(input logic [3:0] s, input logic [2:0] l, input logic [1:0] p,
                     input logic av);
    cfg_we = 1'b1;
    cfg_sel = s;
    cfg_lvl = l;
    cfg_pr = p;
    cfg_av = av;
    @(negedge clk_i);
    cfg_we = 1'b0;
  endtask : cfg

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_defaults;
    periph = 6'h3b;
    lines = 3'h3;
    @(negedge clk_i);
    ack(3'h5, 10'h008, 1'b1, 8'h1d); periph[0] = 1'b0;
    ack(3'h5, 10'h010, 1'b1, 8'h1d); periph[1] = 1'b0;
    ack(3'h4, 10'h002, 1'b1, 8'h1c); lines[1] = 1'b0;
    ack(3'h3, 10'h040, 1'b1, 8'h1b); periph[3] = 1'b0;
    ack(3'h3, 10'h080, 1'b1, 8'h1b); periph[4] = 1'b0;
    ack(3'h3, 10'h100, 1'b1, 8'h1b); periph[5] = 1'b0;
    ack(3'h1, 10'h004, 1'b1, 8'h19); lines[0] = 1'b0;
  endtask : t_defaults

  task automatic t_mask;
    periph = 6'h01;
    mask = 3'h5;
    repeat (3) @(negedge clk_i);
    check(pend, 1'b0);
    done = 1'b1;
    @(negedge clk_i);
    done = 1'b0;
    check(iack, 1'b0);
    mask = 3'h4;
    repeat (2) @(negedge clk_i);
    check(plev, 3'h5);
    ack(3'h5, 10'h008, 1'b1, 8'h1d);
    periph = 6'h00;
  endtask : t_mask

  task automatic t_level7;
    mask = 3'h7;
    periph = 6'h04;
    vec = 8'h40;
    vdly = 5'h03;
    press = 1'b1;
    @(negedge clk_i);
    press = 1'b0;
    @(negedge clk_i);
    ack(3'h7, 10'h001, 1'b1, 8'h1f);
    repeat (3050) @(negedge clk_i);
    ack(3'h7, 10'h020, 1'b0, 8'h40);
    vdly = 5'h00;
    ack(3'h7, 10'h020, 1'b0, 8'h18);
    periph = 6'h00;
    mask = 3'h0;
  endtask : t_level7

  task automatic t_config;
    periph = 6'h03;
    cfg(4'h4, 3'h6, 2'h0, 1'b1);
    ack(3'h6, 10'h010, 1'b1, 8'h1e);
    cfg(4'h3, 3'h6, 2'h1, 1'b0);
    vec = 8'h55;
    vdly = 5'h02;
    ack(3'h6, 10'h008, 1'b0, 8'h55);
    periph = 6'h00;
  endtask : t_config

  task automatic t_encoded;
    enc = 1'b1;
    lines = 3'h2;
    repeat (2) @(negedge clk_i);
    ack(3'h2, 10'h200, 1'b1, 8'h1a);
    lines = 3'h0;
    enc = 1'b0;
  endtask : t_encoded

  // reset, then run every scenario
  initial begin
    {sys_rst_i, done, enc, cfg_we, cfg_av, press, cfg_sel, mask, cfg_lvl} = '0;
    {cfg_pr, lines, periph, vec, vdly, mismatches, cmp_count, cycles} = '0;
    sys_rst_i = 1'b1;
    repeat (6) @(negedge clk_i);
    sys_rst_i = 1'b0;
    @(negedge clk_i);
    t_defaults();
    t_mask();
    t_level7();
    t_config();
    t_encoded();
    stop_test();
  end
endmodule : board_interrupt_priority_logic_tb_top
